/* File: core/hbiv_pkg.sv */
// Purpose: Shared types and constants for the host bus and interrupt vectoring block
// Assumes: One 200 MHz clock, synchronous active-high reset
// Notes: Channel numbers equal the bit index of the pending vector
package hbiv_pkg;
    // ------------------------------------------------------------
    // Sizes and encodings
    // ------------------------------------------------------------
    localparam int NUM_CHAN = 16;
    localparam int CHAN_W = 4;
    localparam int DATA_W = 8;
    localparam int SEL_W = 5;
    localparam logic [DATA_W-1:0] VECTOR_RESET = 8'h0F;
    localparam logic [SEL_W-1:0] SEL_VECTOR = 5'h0B;
    localparam logic [SEL_W-1:0] SEL_PENDING_HI = 5'h05;
    localparam logic [SEL_W-1:0] SEL_PENDING_LO = 5'h06;
    localparam logic [SEL_W-1:0] SEL_MASK_HI = 5'h09;
    localparam logic [SEL_W-1:0] SEL_MASK_LO = 5'h0A;
    // Reset hold time and its cycle count at 200 MHz
    localparam int RESET_MIN_NS = 2000;
    localparam int CLK_PERIOD_NS = 5;
    localparam int RESET_MIN_CYCLES = (RESET_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // ------------------------------------------------------------
    // Bus cycle states
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        HBIV_IDLE = 3'b000,
        HBIV_READ = 3'b001,
        HBIV_WRITE = 3'b010,
        HBIV_VECT = 3'b011,
        HBIV_PASS = 3'b100,
        HBIV_ACK = 3'b101,
        HBIV_END = 3'b110,
        HBIV_WAIT = 3'b111
    } hbiv_state_t;

    // Synchronised host controls
    typedef struct packed {
        logic cs_n;
        logic strobe_n;
        logic rd_wr;
        logic intr_acknowledge_n_n;
        logic chain_in_n;
    } hbiv_ctl_t;

    // Priority encoder result
    typedef struct packed {
        logic hit;
        logic [CHAN_W-1:0] chan;
    } hbiv_pick_t;

    // State of the main module, apart from the source edge flops
    typedef struct packed {
        hbiv_state_t state;
        logic [DATA_W-1:0] vector;
        logic [NUM_CHAN-1:0] pending;
        logic [NUM_CHAN-1:0] mask;
        logic [DATA_W-1:0] dout;
        logic data_oe_n;
        logic ack_n;
        logic ack_oe_n;
        logic irq_n;
        logic chain_out_n;
        logic [CHAN_W-1:0] served;
    } hbiv_state_s_t;
endpackage

/* File: core/hbiv_sync.sv */
// Purpose: Two-flop synchroniser for the asynchronous host pins
// Assumes: Inputs come from outside the clock domain
// Notes: First stage is read only by the second stage
`timescale 1ns/1ps
`default_nettype none
module hbiv_sync #(
    parameter int W = 1,
    parameter logic [W-1:0] INIT = '1
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Data
    input wire logic [W-1:0] d_i,
    output logic [W-1:0] q_o
);
    logic [W-1:0] meta;

    // Idle value on reset keeps strobes inactive
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            meta <= INIT;
            q_o <= INIT;
        end else begin
            meta <= d_i;
            q_o <= meta;
        end
    end
endmodule
`default_nettype wire

/* File: core/hbiv_top.sv */
// Purpose: Host bus slave port with vectored, daisy-chained interrupt acknowledge
// Assumes: Host pins are asynchronous and pass two flops; one 200 MHz clock
// Notes: Timers, serial and I/O ports live elsewhere; they feed irq_src_i
//
// Function
// R1 - Read: drive selected register, then acknowledge
// R2 - Read ends on select or strobe release
// R3 - Write: decode, load register, then acknowledge
// R4 - Write ends, acknowledge driven high, floated
// R5 - Host deskews its own signals and ours
// R6 - Request out while any source pending; code requests only while an unmasked channel is pending
// R7 - Acknowledge cycle returns vector on data
// R8 - Cycle end: ack high, float ack, data
// R9 - Request drops after acknowledge unless more pend
// R10 - Chain in low: vector or pass down
// R11 - Passing down: drive no data, no ack
// R12 - Reset held at least two microseconds
// R13 - Reset clears registers; vector becomes 0Fh
// R14 - Reset disables channels, clears pending, negates outputs
// R15 - Non-muxed slow host: strobe from E
// R16 - Muxed mode needs one dummy access first
// R17 - Fixed priority over pending unmasked channels
// R18 - Input 7 highest, input 0 lowest
// R19 - Vector: programmed upper nibble, channel number
// R20 - Channel codes fixed by priority table
// R21 - All chain members prioritise in parallel
// R22 - Chain in high: stay off bus
`timescale 1ns/1ps
`default_nettype none
module hbiv_top (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Host bus controls (asynchronous)
    input wire logic chip_select_n_i,
    input wire logic data_strobe_n_i,
    input wire logic read_write_i,
    input wire logic intr_acknowledge_n_i,
    input wire logic [hbiv_pkg::SEL_W-1:0] register_select_i,
    input wire logic [hbiv_pkg::DATA_W-1:0] data_i,
    // Bus mode strap, informational only
    input wire logic bus_muxed_select_i,
    // Daisy chain
    input wire logic chain_enable_in_n_i,
    output logic chain_enable_out_n_o,
    // Interrupt sources, one level-edge event per channel code
    input wire logic [hbiv_pkg::NUM_CHAN-1:0] irq_src_i,
    // Data bus drive
    output logic [hbiv_pkg::DATA_W-1:0] data_o,
    output logic data_oe_n_o,
    // Transfer acknowledge, three-state
    output logic transfer_ack_n_o,
    output logic transfer_ack_oe_n_o,
    // Interrupt request, active low, driven straight from a state flop with no output enable
    output logic irq_n_o
);
    // ------------------------------------------------------------
    // Input synchronisers
    // ------------------------------------------------------------
    hbiv_pkg::hbiv_ctl_t ctl_raw;
    hbiv_pkg::hbiv_ctl_t ctl;
    logic [hbiv_pkg::SEL_W-1:0] sel;
    logic [hbiv_pkg::DATA_W-1:0] din;
    logic [hbiv_pkg::NUM_CHAN-1:0] src;
    logic [hbiv_pkg::NUM_CHAN-1:0] src_d;
    hbiv_pkg::hbiv_state_s_t s;
    hbiv_pkg::hbiv_state_s_t next_s;
    hbiv_pkg::hbiv_pick_t pick;

    assign ctl_raw = '{cs_n: chip_select_n_i, strobe_n: data_strobe_n_i, rd_wr: read_write_i,
                       intr_acknowledge_n_n: intr_acknowledge_n_i, chain_in_n: chain_enable_in_n_i};

    hbiv_sync #(.W($bits(hbiv_pkg::hbiv_ctl_t))) u_sync_ctl (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .d_i(ctl_raw),
        .q_o(ctl)
    );

    // Address and data are stable while strobe is low, but still pass two flops
    hbiv_sync #(.W(hbiv_pkg::SEL_W + hbiv_pkg::DATA_W + hbiv_pkg::NUM_CHAN),
                .INIT('0)) u_sync_dat (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .d_i({register_select_i, data_i, irq_src_i}),
        .q_o({sel, din, src})
    );

    // ------------------------------------------------------------
    // Priority encoder
    // ------------------------------------------------------------
    // Highest index wins, so general input 7 (code 1111) beats all others
    function automatic hbiv_pkg::hbiv_pick_t pick_top(input logic [hbiv_pkg::NUM_CHAN-1:0] req);
        hbiv_pkg::hbiv_pick_t r;
        r = '0;
        for (int i = 0; i < hbiv_pkg::NUM_CHAN; i++) begin
            if (req[i]) begin
                r.hit = 1'b1; // R17
                r.chan = i[hbiv_pkg::CHAN_W-1:0]; // R18 R20
            end
        end
        return r;
    endfunction

    // Every chain member runs this every cycle, so it is ready when acknowledge lands
    assign pick = pick_top(s.pending & s.mask); // R17 R21

    // Rising edge of a source marks it pending
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            src_d <= '0;
        end else begin
            src_d <= src;
        end
    end

    // ------------------------------------------------------------
    // Bus cycle and interrupt state
    // ------------------------------------------------------------
    always_comb begin
        logic [hbiv_pkg::NUM_CHAN-1:0] rise;
        logic [hbiv_pkg::NUM_CHAN-1:0] clr;
        logic cyc_end;
        rise = src & ~src_d;
        clr = '0;
        cyc_end = ctl.strobe_n | (ctl.cs_n & ctl.intr_acknowledge_n_n);
        next_s = s;
        case (s.state)
            hbiv_pkg::HBIV_IDLE: begin
                if (!ctl.strobe_n && !ctl.intr_acknowledge_n_n) begin
                    if (ctl.chain_in_n) begin
                        next_s.state = hbiv_pkg::HBIV_WAIT; // R22
                    end else if (pick.hit) begin
                        next_s.state = hbiv_pkg::HBIV_VECT; // R10
                        next_s.served = pick.chan;
                    end else begin
                        next_s.state = hbiv_pkg::HBIV_PASS; // R10
                    end
                end else if (!ctl.strobe_n && !ctl.cs_n) begin
                    next_s.state = ctl.rd_wr ? hbiv_pkg::HBIV_READ : hbiv_pkg::HBIV_WRITE;
                end
            end
            hbiv_pkg::HBIV_READ: begin
                // Data goes out one cycle ahead of the acknowledge
                next_s.data_oe_n = 1'b0; // R1
                case (sel)
                    hbiv_pkg::SEL_VECTOR: next_s.dout = s.vector;
                    hbiv_pkg::SEL_PENDING_HI: next_s.dout = s.pending[15:8];
                    hbiv_pkg::SEL_PENDING_LO: next_s.dout = s.pending[7:0];
                    hbiv_pkg::SEL_MASK_HI: next_s.dout = s.mask[15:8];
                    hbiv_pkg::SEL_MASK_LO: next_s.dout = s.mask[7:0];
                    default: next_s.dout = '0;
                endcase
                next_s.state = hbiv_pkg::HBIV_ACK;
            end
            hbiv_pkg::HBIV_WRITE: begin
                // Load before acknowledging
                case (sel)
                    hbiv_pkg::SEL_VECTOR: next_s.vector = din; // R3
                    hbiv_pkg::SEL_PENDING_HI: clr[15:8] = ~din;
                    hbiv_pkg::SEL_PENDING_LO: clr[7:0] = ~din;
                    hbiv_pkg::SEL_MASK_HI: next_s.mask[15:8] = din;
                    hbiv_pkg::SEL_MASK_LO: next_s.mask[7:0] = din;
                    default: next_s.vector = s.vector;
                endcase
                next_s.state = hbiv_pkg::HBIV_ACK;
            end
            hbiv_pkg::HBIV_VECT: begin
                next_s.dout = {s.vector[7:4], s.served}; // R7 R19
                next_s.data_oe_n = 1'b0;
                clr[s.served] = 1'b1; // R9
                next_s.state = hbiv_pkg::HBIV_ACK;
            end
            hbiv_pkg::HBIV_PASS: begin
                // Passing down keeps data and acknowledge floated
                next_s.chain_out_n = 1'b0; // R10 R11
                if (cyc_end) begin
                    next_s.chain_out_n = 1'b1;
                    next_s.state = hbiv_pkg::HBIV_IDLE;
                end
            end
            hbiv_pkg::HBIV_ACK: begin
                next_s.ack_n = 1'b0; // R1 R3 R7
                next_s.ack_oe_n = 1'b0;
                if (cyc_end) begin
                    next_s.ack_n = 1'b1; // R2 R4 R8
                    next_s.state = hbiv_pkg::HBIV_END;
                end
            end
            hbiv_pkg::HBIV_END: begin
                // One cycle of driven high before releasing the line
                next_s.ack_oe_n = 1'b1; // R2 R4 R8
                next_s.data_oe_n = 1'b1; // R8
                next_s.state = hbiv_pkg::HBIV_IDLE;
            end
            hbiv_pkg::HBIV_WAIT: begin
                next_s.chain_out_n = 1'b1; // R22
                if (cyc_end) begin
                    next_s.state = hbiv_pkg::HBIV_IDLE;
                end
            end
            default: next_s.state = hbiv_pkg::HBIV_IDLE;
        endcase
        // New edges win over a clear in the same cycle
        next_s.pending = (s.pending & ~clr) | rise;
        next_s.irq_n = ~|(next_s.pending & next_s.mask); // R6 R9
    end

    // Reset clears pending and mask, vector to its init value
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            s <= '{state: hbiv_pkg::HBIV_IDLE, vector: hbiv_pkg::VECTOR_RESET, // R13
                   pending: '0, mask: '0, dout: '0, data_oe_n: 1'b1, // R14
                   ack_n: 1'b1, ack_oe_n: 1'b1, irq_n: 1'b1, chain_out_n: 1'b1,
                   served: '0};
        end else begin
            s <= next_s;
        end
    end

    // ------------------------------------------------------------
    // Outputs, all straight from state flops
    // ------------------------------------------------------------
    assign data_o = s.dout;
    assign data_oe_n_o = s.data_oe_n;
    assign transfer_ack_n_o = s.ack_n;
    assign transfer_ack_oe_n_o = s.ack_oe_n;
    assign irq_n_o = s.irq_n;
    assign chain_enable_out_n_o = s.chain_out_n;
endmodule
`default_nettype wire

/* File: verification/hbiv_checker.sv */
// Purpose: Port checks for hbiv_top
// Assumes: Host pins change off the rising edge
// Notes: Bound into every hbiv_top
`timescale 1ns/1ps
`default_nettype none
module hbiv_checker (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Host controls
    input wire logic chip_select_n_i,
    input wire logic data_strobe_n_i,
    input wire logic read_write_i,
    input wire logic intr_acknowledge_n_i,
    input wire logic chain_enable_in_n_i,
    // Block outputs
    input wire logic chain_enable_out_n_o,
    input wire logic data_oe_n_o,
    input wire logic transfer_ack_n_o,
    input wire logic transfer_ack_oe_n_o,
    input wire logic irq_n_o
);
    // ------------------------------------------------------------
    // Properties
    // ------------------------------------------------------------
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    a_ack_in_strobe: assert property ($fell(transfer_ack_n_o) |-> !data_strobe_n_i)
        else $error("ack outside strobe");
    a_data_before_ack: assert property ($fell(transfer_ack_n_o) && read_write_i
        |-> !$past(data_oe_n_o) && !data_oe_n_o)
        else $error("data not driven before ack");
    a_write_no_drive: assert property (!chip_select_n_i && !read_write_i |-> data_oe_n_o)
        else $error("data driven in write");
    a_ack_stands: assert property (!transfer_ack_n_o && !data_strobe_n_i
        |=> !transfer_ack_oe_n_o)
        else $error("ack dropped under strobe");
    // Ack must go high while driven, then float with the data lines
    a_ack_release: assert property ($rose(data_strobe_n_i) && !transfer_ack_n_o
        |-> ##[1:7] (transfer_ack_n_o && !transfer_ack_oe_n_o)
        ##1 (transfer_ack_oe_n_o && data_oe_n_o))
        else $error("ack end sequence wrong");
    a_pass_quiet: assert property (!chain_enable_out_n_o
        |-> data_oe_n_o && transfer_ack_oe_n_o)
        else $error("bus driven while passing");
    a_chain_off: assert property (chain_enable_in_n_i && $past(chain_enable_in_n_i, 4)
        && !intr_acknowledge_n_i
        |-> chain_enable_out_n_o && transfer_ack_oe_n_o && data_oe_n_o)
        else $error("active with chain in high");
    a_reset_idle: assert property ($fell(rst_i) |-> irq_n_o && data_oe_n_o
        && transfer_ack_oe_n_o && chain_enable_out_n_o)
        else $error("outputs not negated by reset");
endmodule
bind hbiv_top hbiv_checker hbiv_checker_inst (
    .clk_i(clk_i), .rst_i(rst_i), .chip_select_n_i(chip_select_n_i),
    .data_strobe_n_i(data_strobe_n_i), .read_write_i(read_write_i),
    .intr_acknowledge_n_i(intr_acknowledge_n_i), .chain_enable_in_n_i(chain_enable_in_n_i),
    .chain_enable_out_n_o(chain_enable_out_n_o), .data_oe_n_o(data_oe_n_o),
    .transfer_ack_n_o(transfer_ack_n_o), .transfer_ack_oe_n_o(transfer_ack_oe_n_o),
    .irq_n_o(irq_n_o));
`default_nettype wire

/* File: verification/hbiv_host.sv */
// Purpose: Host processor model for the block's bus
// Assumes: Pins change at the falling edge
// Notes: Released write data is inverted so stale values never match
`timescale 1ns/1ps
`default_nettype none
module hbiv_host (
    // Clock
    input wire logic clk_i,
    // Pins towards the block
    output logic cs_n_o,
    output logic ds_n_o,
    output logic rw_o,
    output logic intr_acknowledge_n_n_o,
    output logic [4:0] sel_o,
    output logic [7:0] dat_o,
    // Answers from the block
    input wire logic ack_n_i,
    input wire logic ack_oe_n_i,
    input wire logic [7:0] dat_i
);
    // ------------------------------------------------------------
    // Bus cycle
    // ------------------------------------------------------------
    initial begin
        {cs_n_o, ds_n_o, rw_o, intr_acknowledge_n_n_o} = 4'hF;
        sel_o = 5'h00;
        dat_o = 8'h00;
    end
    // Holds everything until ack is seen or 16 cycles pass, then releases the bus
    task automatic access(input logic ia, input logic rw, input logic [4:0] sel,
                          input logic [7:0] wd, output logic [7:0] rd, output logic ok);
        int k;
        rd = 8'h00;
        ok = 1'b0;
        @(negedge clk_i);
        cs_n_o <= ia;
        intr_acknowledge_n_n_o <= !ia;
        rw_o <= rw | ia;
        sel_o <= sel;
        dat_o <= wd;
        ds_n_o <= 1'b0;
        for (k = 0; k < 16 && !ok; k++) begin
            @(posedge clk_i);
            if (ack_oe_n_i === 1'b0 && ack_n_i === 1'b0) begin
                ok = 1'b1;
                rd = dat_i;
            end
        end
        @(negedge clk_i);
        {cs_n_o, ds_n_o, intr_acknowledge_n_n_o} <= 3'h7;
        dat_o <= ~wd;
        repeat (8) @(negedge clk_i);
    endtask
endmodule
`default_nettype wire

/* File: verification/hbiv_top_tb.sv */
// Purpose: Self-checking bench for hbiv_top
// Assumes: Host model drives the bus pins
// Notes: Sources are edge events held high across the acknowledge
`timescale 1ns/1ps
`default_nettype none
module hbiv_top_tb;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic cs_n, ds_n, rw, intr_acknowledge_n_n, chain_in_n, chain_out_n, data_oe_n, ack_n, ack_oe_n, irq_n_o;
    int n_pass = 0;
    logic [4:0] sel;
    logic [7:0] wd, dout, d;
    logic [15:0] src = 16'h0000;
    int mismatches = 0;
    int n_checks = 0;
    int cyc = 0;
    hbiv_top hbiv_top_inst (.clk_i(clk_i), .rst_i(rst_i), .chip_select_n_i(cs_n),
        .data_strobe_n_i(ds_n), .read_write_i(rw), .intr_acknowledge_n_i(intr_acknowledge_n_n),
        .register_select_i(sel), .data_i(wd), .bus_muxed_select_i(1'b0),
        .chain_enable_in_n_i(chain_in_n), .chain_enable_out_n_o(chain_out_n), .irq_src_i(src),
        .data_o(dout), .data_oe_n_o(data_oe_n), .transfer_ack_n_o(ack_n),
        .transfer_ack_oe_n_o(ack_oe_n), .irq_n_o(irq_n_o));
    hbiv_host hbiv_host_inst (.clk_i(clk_i), .cs_n_o(cs_n), .ds_n_o(ds_n), .rw_o(rw),
        .intr_acknowledge_n_n_o(intr_acknowledge_n_n), .sel_o(sel), .dat_o(wd), .ack_n_i(ack_n), .ack_oe_n_i(ack_oe_n),
        .dat_i(dout));
    // ------------------------------------------------------------
    // Clock, timeout and chain monitor
    // ------------------------------------------------------------
    initial forever #2.5 clk_i = ~clk_i;
    always @(posedge clk_i) begin
        cyc++;
        // Counted here only, so scenarios compare snapshots instead of clearing a flag
        if (chain_out_n === 1'b0) n_pass++;
        if (cyc == 5000) begin
            mismatches++;
            summarize();
        end
    end
    // ------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------
    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        n_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("[ERR] %s exp %h got %h", what, exp, got);
        end
    endtask
    task automatic rd(input logic [4:0] a, input logic [7:0] exp);
        logic ok;
        hbiv_host_inst.access(1'b0, 1'b1, a, 8'h00, d, ok);
        chk("read ack", 8'h01, {7'h00, ok});
        chk("read data", exp, d);
    endtask
    task automatic wr(input logic [4:0] a, input logic [7:0] v);
        logic ok;
        hbiv_host_inst.access(1'b0, 1'b0, a, v, d, ok);
        chk("write ack", 8'h01, {7'h00, ok});
    endtask
    task automatic ia(input logic hit, input logic [7:0] exp);
        logic ok;
        hbiv_host_inst.access(1'b1, 1'b1, 5'h00, 8'h00, d, ok);
        chk("intr_acknowledge_n ack", {7'h00, hit}, {7'h00, ok});
        if (hit) chk("vector", exp, d);
    endtask
    // Level settles through the synchronisers, so allow a bounded wait
    task automatic wirq(input logic v);
        for (int k = 0; k < 10 && irq_n_o !== v; k++) @(negedge clk_i);
        chk("irq", {7'h00, v}, {7'h00, irq_n_o});
    endtask
    task automatic summarize;
        $display("checks %0d mismatches %0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic t_regs;
        rd(hbiv_pkg::SEL_VECTOR, hbiv_pkg::VECTOR_RESET);
        rd(hbiv_pkg::SEL_MASK_HI, 8'h00);
        wirq(1'b1);
        wr(hbiv_pkg::SEL_MASK_HI, 8'hFF);
        wr(hbiv_pkg::SEL_MASK_LO, 8'hFF);
        wr(hbiv_pkg::SEL_VECTOR, 8'h40);
        rd(hbiv_pkg::SEL_MASK_LO, 8'hFF);
        rd(5'h1F, 8'h00);
        $display("register test done");
    endtask
    task automatic t_vectors;
        for (int i = 0; i < 16; i++) begin
            src[i] = 1'b1;
            wirq(1'b0);
            ia(1'b1, {4'h4, i[3:0]});
            wirq(1'b1);
            src[i] = 1'b0;
        end
        $display("vector test done");
    endtask
    task automatic t_prio;
        int p0;
        src = 16'h1008;
        wirq(1'b0);
        ia(1'b1, 8'h4C);
        chk("irq held", 8'h00, {7'h00, irq_n_o});
        ia(1'b1, 8'h43);
        src = 16'h0000;
        wr(hbiv_pkg::SEL_MASK_HI, 8'h7F);
        src = 16'h8004;
        wirq(1'b0);
        ia(1'b1, 8'h42);
        wirq(1'b1);
        p0 = n_pass;
        ia(1'b0, 8'h00);
        chk("passed down", 8'h01, {7'h00, n_pass != p0});
        $display("priority test done");
    endtask
    task automatic t_chain;
        int p0;
        wr(hbiv_pkg::SEL_MASK_HI, 8'hFF);
        chain_in_n = 1'b1;
        p0 = n_pass;
        ia(1'b0, 8'h00);
        chk("pass held", 8'h00, {7'h00, n_pass != p0});
        chain_in_n = 1'b0;
        ia(1'b1, 8'h4F);
        wirq(1'b1);
        $display("chain test done");
    endtask
    // Mid-run reset for the full system minimum, with state set up so clearing shows
    task automatic t_reset;
        logic ok;
        src = 16'h0100;
        wirq(1'b0);
        src = 16'h0000;
        rst_i = 1'b1;
        repeat (hbiv_pkg::RESET_MIN_CYCLES) @(negedge clk_i);
        rst_i = 1'b0;
        hbiv_host_inst.access(1'b0, 1'b1, 5'h1F, 8'h00, d, ok);
        rd(hbiv_pkg::SEL_VECTOR, hbiv_pkg::VECTOR_RESET);
        rd(hbiv_pkg::SEL_MASK_LO, 8'h00);
        rd(hbiv_pkg::SEL_PENDING_HI, 8'h00);
        wirq(1'b1);
        $display("reset test done");
    endtask
    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        logic dummy_ok;
        chain_in_n = 1'b0;
        repeat (6) @(negedge clk_i);
        rst_i = 1'b0;
        hbiv_host_inst.access(1'b0, 1'b1, 5'h1F, 8'h00, d, dummy_ok);
        t_regs();
        t_vectors();
        t_prio();
        t_chain();
        t_reset();
        summarize();
    end
endmodule
`default_nettype wire
